// ---- rtl/frame_consts.svh ----
// Constants for the transport frame assembler.
// Assumes inclusion by bare name from the rtl/ folder.
`ifndef FRAME_CONSTS_SVH
`define FRAME_CONSTS_SVH

// Sample widening
`define PAD_ZEROS 2'b00

// Test patterns
`define RPAT_LAST 4'hb
`define CLK_PAT_HI 8'hff
`define CLK_PAT_LO 8'h00
`define RAMP_RESET 8'h00

// Reset values
`define FMT_RESET 4'h2
`define TP_RESET 2'h0
`define CFG_L_RESET 4'h8
`define CFG_M_RESET 3'h2
`define CFG_F_RESET 3'h2
`define CFG_S_RESET 3'h4

`endif

// ---- rtl/frame_pkg.sv ----
// Types for the transport frame assembler.
// Assumes the constants header is included where numbers are needed.
package frame_pkg;

  typedef enum logic [3:0] {
    FMT_4211 = 4'h0,
    FMT_4244 = 4'h1,
    FMT_8224 = 4'h2,
    FMT_4421 = 4'h3,
    FMT_4222 = 4'h4,
    FMT_2242 = 4'h5,
    FMT_2221 = 4'h6,
    FMT_2441 = 4'h7,
    FMT_1241 = 4'h8
  } fmt_e;

  typedef enum logic [1:0] {
    TP_OFF = 2'h0,
    TP_CLOCK = 2'h1,
    TP_RPAT = 2'h2,
    TP_RAMP = 2'h3
  } tp_e;

  typedef logic [15:0] word_t;
  typedef logic [7:0] octet_t;

  typedef struct packed {
    logic en;
    logic other;
    logic [1:0] idx;
    logic hi;
  } route_s;

endpackage

// ---- rtl/test_pattern_gen.sv ----
// Transport test pattern source, one octet per enabled clock.
// Assumes the same clock, reset and clock enable as the assembler.
`timescale 1ns/1ps
`include "frame_consts.svh"

module test_pattern_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Control
  input wire frame_pkg::tp_e sel,
  input wire logic restart,
  // Pattern out
  output frame_pkg::octet_t pat_q
);
  import frame_pkg::*;

  logic [3:0] rpat_idx_q;
  logic clk_ph_q;
  octet_t ramp_q;

  function automatic octet_t rpat_octet(input logic [3:0] i);
    case (i)
      4'h0: rpat_octet = 8'hbe;
      4'h1: rpat_octet = 8'hd7;
      4'h2: rpat_octet = 8'h23;
      4'h3: rpat_octet = 8'h47;
      4'h4: rpat_octet = 8'h6b;
      4'h5: rpat_octet = 8'h8f;
      4'h6: rpat_octet = 8'hb3;
      4'h7: rpat_octet = 8'h14;
      4'h8: rpat_octet = 8'h5e;
      4'h9: rpat_octet = 8'hfb;
      4'ha: rpat_octet = 8'h35;
      4'hb: rpat_octet = 8'h59;
      default: rpat_octet = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencers restart on resync so the receiver sees a known phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rpat_idx_q <= 4'h0;
    end else if (ce) begin
      if (restart || rpat_idx_q == `RPAT_LAST) begin
        rpat_idx_q <= 4'h0;
      end else begin
        rpat_idx_q <= rpat_idx_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_ph_q <= 1'b0;
      ramp_q <= `RAMP_RESET;
    end else if (ce) begin
      clk_ph_q <= restart ? 1'b0 : ~clk_ph_q;
      ramp_q <= restart ? `RAMP_RESET : ramp_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pat_q <= 8'h00;
    end else if (ce) begin
      case (sel)
        TP_CLOCK: pat_q <= clk_ph_q ? `CLK_PAT_LO : `CLK_PAT_HI;
        TP_RPAT: pat_q <= rpat_octet(rpat_idx_q);
        TP_RAMP: pat_q <= ramp_q;
        default: pat_q <= 8'h00;
      endcase
    end
  end

endmodule

// ---- rtl/frame_assembler.sv ----
// Transport-layer frame assembler for a dual-channel 14-bit converter.
// Assumes sample inputs held stable while sample_req_q is high, and a
// downstream scrambler and link layer that honour the lane enables.
//
// Notes on behaviour
// - Three test patterns can replace converter data on every used lane.
// - The patterns include a clock-like pattern and a 12-octet RPAT.
// - The pattern select is a configuration value written by the host.
// - The format is described by lanes, converters, octets and samples.
// - Each 14-bit sample is widened to 16 bits with two zero LSBs.
// - Without decimation the formats are 4211, 4244 and 8224 only.
// - Formats 4211, 4244 run 250-1000 MSPS; 8224 runs 500-1000 MSPS.
// - In 8224 lanes 0..3 carry samples 3, 2, 0, 1 of each channel.
// - In 4211 lane 2 carries the high octet and lane 1 the low octet.
// - In 4244 lane 2 carries samples 0,1 and lane 1 samples 2,3, high first.
// - With decimation the formats are 4421, 2441, 4222, 2242, 2221, 1241.
// - Decimated formats take device clocks from 500 or 300 up to 1000 MHz.
// - In 4222 lane 1 carries sample 0 and lane 0 sample 1, high first.
// - Single-lane formats use lane 1; 1241 sends A then B, B lanes idle.
// - In 4421 lane 1 carries in-phase and lane 0 quadrature, high first.
// - Frame octets may pass a scrambler before the link layer.
`timescale 1ns/1ps
`include "frame_consts.svh"

module frame_assembler (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Configuration
  input wire frame_pkg::fmt_e fmt_sel,
  input wire frame_pkg::tp_e tp_sel,
  input wire logic scramble_en,
  input wire logic sync_n,
  // Sample streams, index is sample number (I=0, Q=1 in IQ formats)
  input wire logic [3:0][13:0] samp_a,
  input wire logic [3:0][13:0] samp_b,
  output logic sample_req_q,
  // Lanes
  output frame_pkg::octet_t chan_a_lane0,
  output frame_pkg::octet_t chan_a_lane1,
  output frame_pkg::octet_t chan_a_lane2,
  output frame_pkg::octet_t chan_a_lane3,
  output frame_pkg::octet_t chan_b_lane0,
  output frame_pkg::octet_t chan_b_lane1,
  output frame_pkg::octet_t chan_b_lane2,
  output frame_pkg::octet_t chan_b_lane3,
  output logic [7:0] lane_en_q,
  output logic frame_start_q,
  output logic scramble_q,
  // Link parameters
  output logic [3:0] cfg_l_q,
  output logic [2:0] cfg_m_q,
  output logic [2:0] cfg_f_q,
  output logic [2:0] cfg_s_q
);
  import frame_pkg::*;

  fmt_e act_fmt_q;
  tp_e tp_q;
  logic [1:0] oct_cnt_q;
  logic [1:0] oct_cnt_d;
  word_t cap_a_q [4];
  word_t cap_b_q [4];
  octet_t pat_q;
  octet_t lane_q [8];
  fmt_e fmt_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Format tables

  function automatic logic [1:0] frame_last(input fmt_e f);
    case (f)
      FMT_4211: frame_last = 2'd0;
      FMT_4244, FMT_2242, FMT_2441, FMT_1241: frame_last = 2'd3;
      default: frame_last = 2'd1;
    endcase
  endfunction

  function automatic route_s route(input fmt_e f, input logic [1:0] lane,
                                   input logic [1:0] k, input logic is_b);
    route_s r;
    r = '0;
    r.hi = ~k[0];
    case (f)
      FMT_4211: begin
        r.en = (lane == 2'd2) || (lane == 2'd1);
        r.hi = (lane == 2'd2);
      end
      FMT_4244: begin
        r.en = (lane == 2'd2) || (lane == 2'd1);
        r.idx = {lane == 2'd1, k[1]};
      end
      FMT_8224: begin
        r.en = 1'b1;
        case (lane)
          2'd0: r.idx = 2'd3;
          2'd1: r.idx = 2'd2;
          2'd2: r.idx = 2'd0;
          default: r.idx = 2'd1;
        endcase
      end
      FMT_4421, FMT_4222: begin
        r.en = (lane == 2'd1) || (lane == 2'd0);
        r.idx = {1'b0, lane == 2'd0};
      end
      FMT_2242, FMT_2441: begin
        r.en = (lane == 2'd1);
        r.idx = {1'b0, k[1]};
      end
      FMT_2221: begin
        r.en = (lane == 2'd1);
      end
      FMT_1241: begin
        r.en = (lane == 2'd1) && !is_b;
        r.other = k[1];
      end
      default: r.en = 1'b0;
    endcase
    route = r;
  endfunction

  // Out-of-range codes fall back to the reset format
  assign fmt_ok = (fmt_sel > FMT_1241) ? fmt_e'(`FMT_RESET) : fmt_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Format and scrambling taken only while the link is held in resync; test pattern select on any enabled clock

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_fmt_q <= fmt_e'(`FMT_RESET);
      scramble_q <= 1'b0;
    end else if (ce && !sync_n) begin
      act_fmt_q <= fmt_ok;
      scramble_q <= scramble_en;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tp_q <= tp_e'(`TP_RESET);
    end else if (ce) begin
      tp_q <= tp_sel;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_l_q <= `CFG_L_RESET;
      cfg_m_q <= `CFG_M_RESET;
      cfg_f_q <= `CFG_F_RESET;
      cfg_s_q <= `CFG_S_RESET;
    end else if (ce) begin
      cfg_f_q <= {1'b0, frame_last(act_fmt_q)} + 3'h1;
      case (act_fmt_q)
        FMT_4211: {cfg_l_q, cfg_m_q, cfg_s_q} <= {4'h4, 3'h2, 3'h1};
        FMT_4244: {cfg_l_q, cfg_m_q, cfg_s_q} <= {4'h4, 3'h2, 3'h4};
        FMT_4421: {cfg_l_q, cfg_m_q, cfg_s_q} <= {4'h4, 3'h4, 3'h1};
        FMT_4222: {cfg_l_q, cfg_m_q, cfg_s_q} <= {4'h4, 3'h2, 3'h2};
        FMT_2242: {cfg_l_q, cfg_m_q, cfg_s_q} <= {4'h2, 3'h2, 3'h2};
        FMT_2221: {cfg_l_q, cfg_m_q, cfg_s_q} <= {4'h2, 3'h2, 3'h1};
        FMT_2441: {cfg_l_q, cfg_m_q, cfg_s_q} <= {4'h2, 3'h4, 3'h1};
        FMT_1241: {cfg_l_q, cfg_m_q, cfg_s_q} <= {4'h1, 3'h2, 3'h1};
        default: {cfg_l_q, cfg_m_q, cfg_s_q} <= {4'h8, 3'h2, 3'h4};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame cadence; the sample rate itself is set by the clock enable,
  // so rate limits are met by how often ce is high

  always_comb begin
    if (!sync_n || oct_cnt_q == frame_last(act_fmt_q)) begin
      oct_cnt_d = 2'd0;
    end else begin
      oct_cnt_d = oct_cnt_q + 2'd1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oct_cnt_q <= 2'd0;
      sample_req_q <= 1'b1;
    end else if (ce) begin
      oct_cnt_q <= oct_cnt_d;
      sample_req_q <= !sync_n || oct_cnt_d == frame_last(act_fmt_q);
    end
  end

  // Whole frame is captured at once; inputs must hold for the request cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        cap_a_q[i] <= 16'h0000;
        cap_b_q[i] <= 16'h0000;
      end
    end else if (ce && sample_req_q) begin
      for (int i = 0; i < 4; i++) begin
        cap_a_q[i] <= {samp_a[i], `PAD_ZEROS};
        cap_b_q[i] <= {samp_b[i], `PAD_ZEROS};
      end
    end
  end

  test_pattern_gen u_pat (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .sel(tp_q),
    .restart(!sync_n),
    .pat_q(pat_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Lane octet mapping

  for (genvar g = 0; g < 8; g++) begin : lane_g
    route_s r;
    word_t w;
    always_comb begin
      r = route(act_fmt_q, 2'(g % 4), oct_cnt_q, g >= 4);
      if ((g >= 4) ^ r.other) begin
        w = cap_b_q[r.idx];
      end else begin
        w = cap_a_q[r.idx];
      end
    end
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        lane_q[g] <= 8'h00;
        lane_en_q[g] <= 1'b0;
      end else if (ce) begin
        lane_en_q[g] <= r.en;
        if (!r.en) begin
          lane_q[g] <= 8'h00;
        end else if (tp_q != TP_OFF) begin
          lane_q[g] <= pat_q;
        end else begin
          lane_q[g] <= r.hi ? w[15:8] : w[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frame_start_q <= 1'b0;
    end else if (ce) begin
      frame_start_q <= sync_n && oct_cnt_q == 2'd0;
    end
  end

  assign chan_a_lane0 = lane_q[0];
  assign chan_a_lane1 = lane_q[1];
  assign chan_a_lane2 = lane_q[2];
  assign chan_a_lane3 = lane_q[3];
  assign chan_b_lane0 = lane_q[4];
  assign chan_b_lane1 = lane_q[5];
  assign chan_b_lane2 = lane_q[6];
  assign chan_b_lane3 = lane_q[7];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [3:0] rpat_run_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rpat_run_q <= 4'h0;
    end else if (!ce || !sync_n || tp_q != TP_RPAT) begin
      rpat_run_q <= 4'h0;
    end else if (rpat_run_q != 4'hf) begin
      rpat_run_q <= rpat_run_q + 4'h1;
    end
  end

  rpat_period_a: assert property (@(posedge clk) disable iff (!rstn)
    rpat_run_q >= 4'he && lane_en_q[1] |-> chan_a_lane1 == $past(chan_a_lane1, 12))
    else $error("rpat does not repeat every 12 octets");

  fmt_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    $changed(act_fmt_q) |-> $past(!sync_n))
    else $error("format changed outside resync");

  idle_lane_a: assert property (@(posedge clk) disable iff (!rstn)
    !lane_en_q[3] |-> chan_a_lane3 == 8'h00)
    else $error("unused lane not idle");

  pad_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && act_fmt_q == FMT_4211 && tp_q == TP_OFF |=>
    chan_a_lane1[1:0] == 2'b00)
    else $error("padding bits not zero");

  split_4211_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && act_fmt_q == FMT_4211 && tp_q == TP_OFF |=>
    {chan_b_lane2, chan_b_lane1} == $past(cap_b_q[0]))
    else $error("4211 octet split wrong");

  swap_8224_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && act_fmt_q == FMT_8224 && tp_q == TP_OFF && oct_cnt_q == 2'd0 |=>
    chan_a_lane2 == $past(cap_a_q[0][15:8]) &&
    chan_a_lane0 == $past(cap_a_q[3][15:8]) && lane_en_q == 8'hff)
    else $error("8224 lane order wrong");

  order_4244_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && act_fmt_q == FMT_4244 && tp_q == TP_OFF && oct_cnt_q == 2'd3 |=>
    chan_a_lane1 == $past(cap_a_q[3][7:0]))
    else $error("4244 lane 1 order wrong");

  single_1241_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && act_fmt_q == FMT_1241 |=> lane_en_q == 8'h02)
    else $error("1241 lane use wrong");

  octet_range_a: assert property (@(posedge clk) disable iff (!rstn)
    oct_cnt_q <= frame_last(act_fmt_q))
    else $error("octet counter beyond frame length");

  test_over_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && tp_q != TP_OFF && lane_en_q[1] && $past(ce) && $past(lane_en_q[1])
    |=> chan_a_lane1 == $past(pat_q))
    else $error("test pattern not on lane");

endmodule

// ---- tb/link_receiver.sv ----
// Behavioural receiver that faces the frame assembler lanes.
// Assumes the bench pulses resync for one cycle to ask for a new link.
`timescale 1ns/1ps

module link_receiver (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bench control
  input wire logic resync,
  // Towards the transmitter
  output logic sync_n
);
  logic [2:0] hold_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sync low from reset and for four cycles after each request,
  // long enough for the transmitter to take a new format
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= 3'h4;
    end else if (resync) begin
      hold_q <= 3'h4;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end
  end

  assign sync_n = (hold_q == 3'h0);
endmodule

// ---- tb/frame_assembler_tb_top.sv ----
// Self-checking bench for the transport frame assembler.
// Assumes the receiver model drives sync and the bench owns all else.
`timescale 1ns/1ps

module frame_assembler_tb_top;
  import frame_pkg::*;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  fmt_e fmt_sel = FMT_8224;
  tp_e tp_sel = TP_OFF;
  logic scramble_en = 1'b0;
  logic sync_n;
  logic resync = 1'b0;
  logic [3:0][13:0] samp_a = '0;
  logic [3:0][13:0] samp_b = '0;
  logic [7:0][7:0] ln;
  logic [7:0] lane_en_q;
  logic sample_req_q, frame_start_q, scramble_q;
  logic [3:0] cfg_l_q;
  logic [2:0] cfg_m_q, cfg_f_q, cfg_s_q;
  integer seed = 65798;
  int failures = 0;
  int num_checks = 0;
  bit rnd = 1'b0;
  logic was;
  logic [63:0] prev;
  logic [63:0] got [$];
  logic [15:0] lmfs_t [9] = '{16'h4211, 16'h4244, 16'h8224, 16'h4421,
    16'h4222, 16'h2242, 16'h2221, 16'h2441, 16'h1241};
  logic [7:0] en_t [9] = '{8'h66, 8'h66, 8'hff, 8'h33, 8'h33, 8'h22,
    8'h22, 8'h22, 8'h02};
  logic [7:0] rpat [12] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
    8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};

  always #2 clk = ~clk;

  frame_assembler frame_assembler_i (
    .clk(clk), .rstn(rstn), .ce(ce), .fmt_sel(fmt_sel), .tp_sel(tp_sel),
    .scramble_en(scramble_en), .sync_n(sync_n), .samp_a(samp_a),
    .samp_b(samp_b), .sample_req_q(sample_req_q),
    .chan_a_lane0(ln[0]), .chan_a_lane1(ln[1]), .chan_a_lane2(ln[2]),
    .chan_a_lane3(ln[3]), .chan_b_lane0(ln[4]), .chan_b_lane1(ln[5]),
    .chan_b_lane2(ln[6]), .chan_b_lane3(ln[7]), .lane_en_q(lane_en_q),
    .frame_start_q(frame_start_q), .scramble_q(scramble_q),
    .cfg_l_q(cfg_l_q), .cfg_m_q(cfg_m_q), .cfg_f_q(cfg_f_q),
    .cfg_s_q(cfg_s_q));

  link_receiver link_receiver_i (
    .clk(clk), .rstn(rstn), .resync(resync), .sync_n(sync_n));

  ////////////////////////////////////////////////////////////////////////////
  // Expected octet of lane l (0-3 A, 4-7 B) at frame position k
  function automatic logic [7:0] oct(fmt_e f, int l, int k);
    int s;
    logic b;
    logic [15:0] w;
    b = l > 3;
    case (f)
      FMT_4211: s = (l % 4 == 2 || l % 4 == 1) ? 0 : -1;
      FMT_4244: s = l%4 == 2 ? k/2 : l%4 == 1 ? 2 + k/2 : -1;
      FMT_8224: s = l%4 == 0 ? 3 : l%4 == 1 ? 2 : l%4 == 2 ? 0 : 1;
      FMT_4421, FMT_4222: s = l%4 == 1 ? 0 : l%4 == 0 ? 1 : -1;
      FMT_2221: s = l % 4 == 1 ? 0 : -1;
      FMT_1241: begin
        s = l == 1 ? 0 : -1;
        b = k > 1;
      end
      default: s = l % 4 == 1 ? k / 2 : -1;
    endcase
    if (s < 0) return 8'h00;
    w = {b ? samp_b[s] : samp_a[s], 2'b00};
    if (f == FMT_4211) return l % 4 == 2 ? w[15:8] : w[7:0];
    return k % 2 ? w[7:0] : w[15:8];
  endfunction

  function automatic logic [63:0] frame_vec(fmt_e f, int k);
    logic [63:0] v;
    for (int l = 0; l < 8; l++) v[8*l +: 8] = oct(f, l, k);
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_lane(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t lanes got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_cfg(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t cfg got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("Counts: checks=%0d mismatches=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Random clock-enable gaps only outside resync, so the format is taken
  task automatic step();
    @(posedge clk);
    was = ce;
    #1;
    ce = rnd ? ($random(seed) % 4 != 0) : 1'b1;
  endtask

  task automatic grab(input int n, input bit need_fs);
    int i;
    int st;
    logic [15:0] e;
    got = {};
    st = 0;
    for (i = 0; i < 400 && got.size() < n; i++) begin
      prev = ln;
      step();
      if (!was) chk_lane(ln, prev);
      else begin
        if (frame_start_q === 1'b1) st++;
        if (!need_fs || st >= 2) begin
          // Frame start on octet 0, capture request one octet before the end
          e = {14'h0, got.size() == 0, (got.size() + 2) % n == 0};
          if (need_fs) chk_cfg({14'h0, frame_start_q, sample_req_q}, e);
          got.push_back(ln);
        end
      end
    end
    if (got.size() < n) begin
      failures++;
      tally_and_finish();
    end
  endtask

  task automatic do_sync();
    int i;
    rnd = 1'b0;
    resync = 1'b1;
    step();
    resync = 1'b0;
    for (i = 0; i < 50 && sync_n !== 1'b1; i++) step();
    if (i == 50) begin
      failures++;
      tally_and_finish();
    end
    rnd = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic run_fmt(input logic [3:0] code);
    fmt_e f;
    logic [15:0] p;
    f = (code > 4'h8) ? FMT_8224 : fmt_e'(code);
    p = lmfs_t[f];
    fmt_sel = fmt_e'(code);
    tp_sel = TP_OFF;
    scramble_en = 1'($random(seed));
    for (int k = 0; k < 4; k++) begin
      samp_a[k] = 14'($random(seed));
      samp_b[k] = 14'($random(seed));
    end
    if (code == 4'h1) begin
      samp_a = {4{14'h3fff}};
      samp_b = {4{14'h2001}};
    end
    do_sync();
    grab(p[7:4], 1'b1);
    for (int k = 0; k < p[7:4]; k++) begin
      chk_lane(got[k], frame_vec(f, k));
    end
    chk_cfg({3'h0, cfg_l_q, cfg_m_q, cfg_f_q, cfg_s_q},
      {3'h0, p[15:12], p[10:8], p[6:4], p[2:0]});
    chk_cfg({7'h0, scramble_q, lane_en_q}, {7'h0, scramble_en, en_t[f]});
    $display("Test format code %h done", code);
  endtask

  task automatic run_tp(input tp_e t);
    int j;
    logic [7:0] p;
    tp_sel = t;
    // Unbroken enables so the 12-octet repeat check gets to fire
    rnd = (t != TP_RPAT);
    grab(6, 1'b0);
    grab(24, 1'b0);
    p = got[0][7:0];
    j = 0;
    for (int i = 0; i < 12; i++) if (rpat[i] === p) j = i;
    for (int i = 0; i < 24; i++) begin
      case (t)
        TP_CLOCK: p = i == 0 ? (p === 8'h00 ? 8'h00 : 8'hff) : ~p;
        TP_RPAT: p = rpat[(j + i) % 12];
        default: p = i == 0 ? p : p + 8'h01;
      endcase
      chk_lane(got[i], {8{p}});
    end
    $display("Test pattern %h done", t);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    chk_cfg({3'h0, cfg_l_q, cfg_m_q, cfg_f_q, cfg_s_q}, 16'h1094);
    chk_cfg({8'h0, lane_en_q}, 16'h0000);
    #1;
    rstn = 1'b1;
    for (int c = 0; c < 10; c++) run_fmt(c == 9 ? 4'hf : 4'(c));
    repeat (6) run_fmt(4'($unsigned($random(seed)) % 9));
    run_fmt(4'h0);
    // A format request without resync must not disturb the link
    fmt_sel = FMT_4244;
    grab(8, 1'b0);
    chk_cfg({3'h0, cfg_l_q, cfg_m_q, cfg_f_q, cfg_s_q}, 16'h0889);
    run_fmt(4'h2);
    run_tp(TP_CLOCK);
    run_tp(TP_RPAT);
    run_tp(TP_RAMP);
    run_fmt(4'h2);
    tally_and_finish();
  end
endmodule
